// ---- hdl/vopp_top.sv ----
// Video output post processor: delay, polarity, range, panels, frame, blanking
//
// Functional notes
// R1: Inside the blanking window luma is forced to black and chroma to colourless.
// R2: Blanking is the last operation before samples leave for the converters.
// R3: Inside the side-panel horizontal window all three samples take panel values.
// R4: Panel colour is an 8-bit luma MSB value and 4-bit MSB values per chroma component.
// R5: A second window bounds a rectangular picture-in-picture frame border.
// R6: Frame border thickness is set apart vertically and horizontally, 1 to 15 pixels.
// R7: Border pixels use the side-panel colour; there is no separate frame colour.
// R8: A range select puts the nominal luma in 9 or 10 bits of the converter word.
// R9: In 9-bit range the spare code space carries undershoot and overshoot unclipped.
// R10: In 10-bit range luma undershoot and overshoot saturate at the code limits.
// R11: A luma delay setting shifts luma against chroma over 16 positions.
// R12: Delay setting zero keeps luma and chroma aligned as at the input.
// R13: Other settings span eight samples less to seven samples more luma delay.
// R14: A control bit inverts both chroma outputs when set.
// R15: Output is 4:4:4 as three 10-bit words at the 32 MHz sample rate.
// R16: Blanking beats frame border, and frame border beats side panels.
// R17: Unprogrammed low bits of panel values are filled with zeros.
`timescale 1ns/1ps
`default_nettype none
`include "vopp_cfg.svh"
module vopp_top
  import vopp_pkg::*;
#(
  parameter int HW = `VOPP_HPOS_W,
  parameter int VW = `VOPP_VPOS_W,
  parameter int FIFO_DEPTH = `VOPP_FIFO_DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // Upstream pixel stream; y signed 11-bit with headroom, u/v twos complement
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_sol,
  input wire logic in_sof,
  input wire logic signed [10:0] in_y,
  input wire logic signed [9:0] in_u,
  input wire logic signed [9:0] in_v,
  // Converter side
  output logic out_valid,
  input wire logic out_ready,
  output logic [9:0] out_y,
  output logic [9:0] out_u,
  output logic [9:0] out_v,
  // Controls
  input wire logic [HW-1:0] blank_hstart,
  input wire logic [HW-1:0] blank_hstop,
  input wire logic [VW-1:0] blank_vstart,
  input wire logic [VW-1:0] blank_vstop,
  input wire logic [HW-1:0] panel_hstart,
  input wire logic [HW-1:0] panel_hstop,
  input wire logic [7:0] panel_y,
  input wire logic [3:0] panel_u,
  input wire logic [3:0] panel_v,
  input wire logic [HW-1:0] frame_hstart,
  input wire logic [HW-1:0] frame_hstop,
  input wire logic [VW-1:0] frame_vstart,
  input wire logic [VW-1:0] frame_vstop,
  input wire logic [3:0] frame_height,
  input wire logic [3:0] frame_width,
  input wire logic range_10bit,
  input wire logic [3:0] luma_delay,
  input wire logic chroma_polarity_flip,
  // Status
  output logic [HW-1:0] cur_hpos,
  output logic [VW-1:0] cur_vpos
);
  // Pipeline advances when the output FIFO has room or st2_valid_r is low
  vopp_stream_if #(.W(30)) fin_s ();
  vopp_stream_if #(.W(30)) fout_s ();

  logic [HW-1:0] hpos_r;
  logic [VW-1:0] vpos_r;
  logic st1_valid_r;
  logic [HW-1:0] st1_h_r;
  logic [VW-1:0] st1_v_r;
  logic signed [10:0] st1_y_r;
  logic signed [9:0] st1_u_r;
  logic signed [9:0] st1_v_c_r;
  logic st2_valid_r;
  logic [29:0] st2_data_r;
  logic out_valid_r;
  logic [29:0] out_data_r;
  logic [3:0] fill_r;
  logic fresh_r;

  wire adv = fin_s.ready || !st2_valid_r;
  wire take = in_valid && adv;
  assign in_ready = adv;

  // Pixel position counters
  wire [HW-1:0] hpos_now = in_sol ? '0 : hpos_r;
  wire [VW-1:0] vpos_now = in_sof ? '0 : (in_sol ? vpos_r + 1'b1 : vpos_r);
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hpos_r <= '0;
      vpos_r <= '0;
    end else if (take) begin
      hpos_r <= hpos_now + 1'b1;
      vpos_r <= vpos_now;
    end
  end

  // Luma delay: tap 8 is the aligned point, chroma always takes tap 8
  wire [3:0] y_tap = luma_delay ^ 4'h8; // R11 R12 R13
  logic [10:0] y_dly;
  logic [9:0] u_dly;
  logic [9:0] v_dly;
  logic [HW-1:0] h_dly;
  logic [VW-1:0] vp_dly;
  vopp_ydelay #(.W(11), .DEPTH(`VOPP_DLY_DEPTH)) u_ydly (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .adv(take),
    .din(in_y),
    .tap(y_tap),
    .dout(y_dly)
  );
  vopp_ydelay #(.W(20), .DEPTH(`VOPP_DLY_DEPTH)) u_cdly (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .adv(take),
    .din({in_u, in_v}),
    .tap(4'h8),
    .dout({u_dly, v_dly})
  );
  vopp_ydelay #(.W(HW+VW), .DEPTH(`VOPP_DLY_DEPTH)) u_pdly (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .adv(take),
    .din({hpos_now, vpos_now}),
    .tap(4'h8),
    .dout({h_dly, vp_dly})
  );

  // Centre tap holds a real sample only after nine takes; the first eight are reset fill
  wire primed = (fill_r == 4'h8); // R12 R13
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fill_r <= 4'h0;
      fresh_r <= 1'b0;
    end else begin
      if (take && !primed) begin
        fill_r <= fill_r + 4'h1;
      end
      if (take && primed) begin
        fresh_r <= 1'b1;
      end else if (adv) begin
        fresh_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st1_valid_r <= 1'b0;
      st1_h_r <= '0;
      st1_v_r <= '0;
      st1_y_r <= '0;
      st1_u_r <= '0;
      st1_v_c_r <= '0;
    end else if (adv) begin
      st1_valid_r <= fresh_r;
      st1_h_r <= h_dly;
      st1_v_r <= vp_dly;
      st1_y_r <= y_dly;
      st1_u_r <= u_dly;
      st1_v_c_r <= v_dly;
    end
  end

  // Luma range mapping
  wire signed [11:0] y9 = 12'(signed'(st1_y_r) >>> 1) + 12'(`VOPP_Y9_OFFSET); // R8 R9
  wire signed [11:0] y10 = 12'(st1_y_r); // R8
  wire signed [11:0] y_sel = range_10bit ? y10 : y9;
  wire [9:0] y_clip = (y_sel > 12'(`VOPP_Y10_MAX)) ? 10'h3FF :
                      (y_sel < 12'(`VOPP_Y10_MIN)) ? 10'h000 : y_sel[9:0]; // R10

  // Chroma polarity, saturating the one code that has no negation
  wire [9:0] u_inv = (st1_u_r == -10'sh200) ? 10'h1FF : 10'(-st1_u_r);
  wire [9:0] v_inv = (st1_v_c_r == -10'sh200) ? 10'h1FF : 10'(-st1_v_c_r);
  wire [9:0] u_pol = chroma_polarity_flip ? u_inv : st1_u_r; // R14
  wire [9:0] v_pol = chroma_polarity_flip ? v_inv : st1_v_c_r; // R14

  // Windows
  wire in_blank = (st1_h_r >= blank_hstart) && (st1_h_r < blank_hstop) &&
                  (st1_v_r >= blank_vstart) && (st1_v_r < blank_vstop); // R1
  wire in_panel = (st1_h_r >= panel_hstart) && (st1_h_r < panel_hstop); // R3
  wire in_frame_box = (st1_h_r >= frame_hstart) && (st1_h_r < frame_hstop) &&
                      (st1_v_r >= frame_vstart) && (st1_v_r < frame_vstop); // R5
  wire [3:0] fw = (frame_width == 4'h0) ? 4'h1 : frame_width; // R6
  wire [3:0] fh = (frame_height == 4'h0) ? 4'h1 : frame_height; // R6
  wire near_left = (st1_h_r - frame_hstart) < HW'(fw);
  wire near_right = (frame_hstop - st1_h_r) <= HW'(fw);
  wire near_top = (st1_v_r - frame_vstart) < VW'(fh);
  wire near_bot = (frame_vstop - st1_v_r) <= VW'(fh);
  wire in_border = in_frame_box && (near_left || near_right || near_top || near_bot); // R5 R6

  // Priority selection
  vopp_src_e src;
  assign src = in_blank ? VOPP_SRC_BLANK :
               in_border ? VOPP_SRC_FRAME :
               in_panel ? VOPP_SRC_PANEL : VOPP_SRC_PASS; // R16

  // Panel colour, zero-filled low bits
  wire [9:0] pan_y = {panel_y, 2'b00}; // R4 R17
  wire [9:0] pan_u = {panel_u, 6'h00}; // R4 R17
  wire [9:0] pan_v = {panel_v, 6'h00}; // R4 R17

  logic [9:0] sel_y;
  logic [9:0] sel_u;
  logic [9:0] sel_v;
  always_comb begin
    case (src)
      VOPP_SRC_BLANK: begin
        sel_y = `VOPP_BLACK_Y; // R1 R2
        sel_u = `VOPP_GREY_C; // R1 R2
        sel_v = `VOPP_GREY_C;
      end
      VOPP_SRC_FRAME, VOPP_SRC_PANEL: begin
        sel_y = pan_y; // R3 R7
        sel_u = pan_u; // R7
        sel_v = pan_v;
      end
      VOPP_SRC_PASS: begin
        sel_y = y_clip;
        sel_u = u_pol;
        sel_v = v_pol;
      end
      default: begin
        sel_y = `VOPP_BLACK_Y;
        sel_u = `VOPP_GREY_C;
        sel_v = `VOPP_GREY_C;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st2_valid_r <= 1'b0;
      st2_data_r <= '0;
    end else if (adv) begin
      st2_valid_r <= st1_valid_r;
      st2_data_r <= {sel_y, sel_u, sel_v};
    end
  end

  assign fin_s.valid = st2_valid_r;
  assign fin_s.data = st2_data_r;

  vopp_fifo #(.W(30), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_s(fin_s),
    .out_s(fout_s)
  );

  // Registered output stage feeding the converters
  wire out_free = !out_valid_r || out_ready;
  assign fout_s.ready = out_free;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      out_valid_r <= 1'b0;
      out_data_r <= '0;
    end else if (out_free) begin
      out_valid_r <= fout_s.valid;
      if (fout_s.valid) begin
        out_data_r <= fout_s.data; // R15
      end
    end
  end
  assign out_valid = out_valid_r;
  assign out_y = out_data_r[29:20];
  assign out_u = out_data_r[19:10];
  assign out_v = out_data_r[9:0];
  assign cur_hpos = hpos_r;
  assign cur_vpos = vpos_r;
endmodule
`default_nettype wire

// ---- common/vopp_cfg.svh ----
// Constants for the video output post processor
`ifndef VOPP_CFG_SVH
`define VOPP_CFG_SVH
`define VOPP_HPOS_W 10
`define VOPP_VPOS_W 10
`define VOPP_SAMPLE_W 10
`define VOPP_IN_Y_W 10
`define VOPP_PANEL_Y_W 8
`define VOPP_PANEL_C_W 4
`define VOPP_THICK_W 4
`define VOPP_YDLY_W 4
`define VOPP_DLY_DEPTH 16
`define VOPP_DLY_CENTER 8
`define VOPP_FIFO_DEPTH 8
`define VOPP_BLACK_Y 10'h000
`define VOPP_GREY_C 10'h000
`define VOPP_Y9_OFFSET 11'sh080
`define VOPP_Y10_MAX 11'sh3FF
`define VOPP_Y10_MIN 11'sh000
`define VOPP_C_MAX 11'sh1FF
`define VOPP_C_MIN (-11'sh200)
`endif

// ---- common/vopp_pkg.sv ----
// Types for the video output post processor
package vopp_pkg;
  typedef enum logic [3:0] {
    VOPP_SRC_PASS = 4'h1,
    VOPP_SRC_PANEL = 4'h2,
    VOPP_SRC_FRAME = 4'h4,
    VOPP_SRC_BLANK = 4'h8
  } vopp_src_e;
  typedef logic [9:0] vopp_sample_t;
endpackage

// ---- common/vopp_stream_if.sv ----
// Pixel stream between the post processor stages
`timescale 1ns/1ps
`default_nettype none
interface vopp_stream_if #(parameter int W = 30);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ---- hdl/vopp_fifo.sv ----
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module vopp_fifo #(
  parameter int W = 30,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  vopp_stream_if.snk in_s,
  vopp_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_r;
  logic [AW-1:0] rd_r;
  logic [AW:0] cnt_r;
  wire push = in_s.valid && in_s.ready;
  wire pop = out_s.valid && out_s.ready;
  assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
  assign out_s.valid = (cnt_r != '0);
  assign out_s.data = mem[rd_r];
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_r] <= in_s.data;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_r <= '0;
      rd_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- hdl/vopp_ydelay.sv ----
// Luma delay line, tap selected as an absolute index into the line
`timescale 1ns/1ps
`default_nettype none
`include "vopp_cfg.svh"
module vopp_ydelay #(
  parameter int W = 10,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic adv,
  input wire logic [W-1:0] din,
  input wire logic [3:0] tap,
  output logic [W-1:0] dout
);
  logic [W-1:0] line_r [DEPTH];
  assign dout = line_r[tap];
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < DEPTH; i++) begin
        line_r[i] <= '0;
      end
    end else if (adv) begin
      line_r[0] <= din;
      for (int i = 1; i < DEPTH; i++) begin
        line_r[i] <= line_r[i-1];
      end
    end
  end
endmodule
`default_nettype wire

// ---- bench/vopp_properties.sv ----
// Port checker of the video output post processor
`timescale 1ns/1ps
`default_nettype none
`include "vopp_cfg.svh"
module vopp_properties #(
  parameter int HW = 10,
  parameter int VW = 10
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic [9:0] out_y,
  input wire logic [9:0] out_u,
  input wire logic [9:0] out_v,
  input wire logic [HW-1:0] blank_hstart,
  input wire logic [HW-1:0] blank_hstop,
  input wire logic [VW-1:0] blank_vstart,
  input wire logic [VW-1:0] blank_vstop,
  input wire logic [HW-1:0] panel_hstart,
  input wire logic [HW-1:0] panel_hstop,
  input wire logic [7:0] panel_y,
  input wire logic [3:0] panel_u,
  input wire logic [3:0] panel_v,
  input wire logic [HW-1:0] frame_hstart,
  input wire logic [HW-1:0] frame_hstop
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  logic [15:0] ntake_r;
  logic [15:0] nout_r;
  wire full_blank = blank_hstart == '0 && blank_hstop == '1 && blank_vstart == '0 && blank_vstop == '1;
  wire full_panel = panel_hstart == '0 && panel_hstop == '1 && blank_hstart == blank_hstop
    && frame_hstart == frame_hstop;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ntake_r <= '0;
      nout_r <= '0;
    end else begin
      ntake_r <= ntake_r + 16'(in_valid && in_ready);
      nout_r <= nout_r + 16'(out_valid && out_ready);
    end
  end
  property p_hold_valid;
    out_valid && !out_ready |=> out_valid;
  endproperty
  a_hold_valid: assert property (p_hold_valid) else $error("output dropped before taken");
  property p_hold_data;
    out_valid && !out_ready |=> $stable(out_y) && $stable(out_u) && $stable(out_v);
  endproperty
  a_hold_data: assert property (p_hold_data) else $error("output changed before taken");
  property p_reset_idle;
    $rose(rst_b) |-> !out_valid && in_ready;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle after reset");
  property p_lookahead;
    out_valid |-> ntake_r > nout_r + 16'h0008;
  endproperty
  a_lookahead: assert property (p_lookahead) else $error("output before eight later samples");
  property p_refuse;
    !in_ready |-> out_valid;
  endproperty
  a_refuse: assert property (p_refuse) else $error("input refused while output empty");
  property p_blank;
    out_valid && full_blank |-> out_y == `VOPP_BLACK_Y && out_u == `VOPP_GREY_C && out_v == `VOPP_GREY_C;
  endproperty
  a_blank: assert property (p_blank) else $error("blanked sample not black");
  property p_panel_y;
    out_valid && full_panel |-> out_y == {panel_y, 2'h0};
  endproperty
  a_panel_y: assert property (p_panel_y) else $error("panel luma wrong");
  property p_panel_c;
    out_valid && full_panel |-> out_u == {panel_u, 6'h00} && out_v == {panel_v, 6'h00};
  endproperty
  a_panel_c: assert property (p_panel_c) else $error("panel chroma wrong");
endmodule
bind vopp_top vopp_properties #(.HW(HW), .VW(VW)) u_vopp_properties (.*);
`default_nettype wire

// ---- bench/vopp_dac_model.sv ----
// Converter side model, takes samples with optional random stalls
`timescale 1ns/1ps
`default_nettype none
module vopp_dac_model (
  input wire logic ref_clk,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [9:0] out_y,
  input wire logic [9:0] out_u,
  input wire logic [9:0] out_v
);
  logic [29:0] got[$];
  initial out_ready = 1'b1;
  always @(posedge ref_clk) begin
    if (out_valid === 1'b1 && out_ready) got.push_back({out_y, out_u, out_v});
    #1 out_ready = !stall || $urandom_range(0, 2) == 0;
  end
endmodule
`default_nettype wire

// ---- bench/tb_video_output_post_processor.sv ----
// Self-checking bench of the video output post processor
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %s exp %h got %h", nm, e, a); end end
module tb_video_output_post_processor;
  localparam int N = 96;
  logic ref_clk = 0, rst_b = 0, in_valid = 0, in_sol = 0, in_sof = 0, range_10bit = 0, stall = 0;
  logic chroma_polarity_flip = 0;
  logic in_ready, out_valid, out_ready;
  logic signed [10:0] in_y = 0;
  logic signed [9:0] in_u = 0, in_v = 0;
  logic [9:0] out_y, out_u, out_v, cur_hpos, cur_vpos;
  logic [9:0] blank_hstart = 0, blank_hstop = 0, blank_vstart = 0, blank_vstop = 0, panel_hstart = 0;
  logic [9:0] panel_hstop = 0, frame_hstart = 0, frame_hstop = 0, frame_vstart = 0, frame_vstop = 0;
  logic [7:0] panel_y = 0;
  logic [3:0] panel_u = 0, panel_v = 0, frame_height = 1, frame_width = 1, luma_delay = 0;
  int ys[N+8], us[N+8], vs[N+8];
  int n_errors = 0, checked = 0;
  always #4 ref_clk = ~ref_clk;
  vopp_top u_vopp_top (.*);
  vopp_dac_model u_vopp_dac_model (.*);
  function automatic logic [9:0] rnd(int m);
    return 10'($urandom_range(0, m));
  endfunction
  // Reference sample for output index k, position from the chroma-aligned sample
  function automatic logic [29:0] expect_at(int k);
    int h, l, d, y, u, v;
    logic fr;
    h = k % 16;
    l = k / 16;
    d = $signed(luma_delay);
    y = k >= d ? ys[k-d] : 0;
    if (!range_10bit) y = (y >>> 1) + 128;
    if (y < 0) y = 0;
    if (y > 1023) y = 1023;
    u = chroma_polarity_flip ? -us[k] : us[k];
    v = chroma_polarity_flip ? -vs[k] : vs[k];
    if (u > 511) u = 511;
    if (v > 511) v = 511;
    fr = h >= frame_hstart && h < frame_hstop && l >= frame_vstart && l < frame_vstop && (h < frame_hstart
      + frame_width || h + frame_width >= frame_hstop || l < frame_vstart + frame_height
      || l + frame_height >= frame_vstop);
    if (fr || (h >= panel_hstart && h < panel_hstop)) begin
      y = {panel_y, 2'h0};
      u = {panel_u, 6'h00};
      v = {panel_v, 6'h00};
    end
    if (h >= blank_hstart && h < blank_hstop && l >= blank_vstart && l < blank_vstop) begin
      y = 0;
      u = 0;
      v = 0;
    end
    return {10'(y), 10'(u), 10'(v)};
  endfunction
  task summarize;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    int t, k, w;
    logic [29:0] e, g;
    void'($urandom(49311));
    for (t = 0; t < 18; t++) begin
      @(posedge ref_clk);
      #1;
      rst_b = 0;
      {blank_hstart, blank_hstop, panel_hstart, panel_hstop} = {rnd(20), rnd(20), rnd(20), rnd(20)};
      {frame_hstart, frame_hstop, blank_vstart, blank_vstop} = {rnd(20), rnd(20), rnd(7), rnd(7)};
      {frame_vstart, frame_vstop, panel_y, panel_u, panel_v} = {rnd(7), rnd(7), 16'($urandom)};
      frame_width = 4'($urandom_range(1, 15));
      frame_height = 4'($urandom_range(1, 15));
      {range_10bit, chroma_polarity_flip} = 2'($urandom);
      luma_delay = 4'(t);
      stall = 1'(t % 2);
      if (t == 16) begin
        blank_hstop = blank_hstart;
        frame_hstop = frame_hstart;
      end
      if (t >= 16) begin
        panel_hstart = '0;
        panel_hstop = '1;
      end
      if (t == 17) begin
        {blank_hstart, blank_vstart, blank_hstop, blank_vstop} = {20'h00000, 20'hFFFFF};
      end
      for (k = 0; k < N + 8; k++) begin
        ys[k] = $urandom_range(0, 1223) - 200;
        us[k] = $urandom_range(0, 1023) - 512;
        vs[k] = $urandom_range(0, 1023) - 512;
      end
      u_vopp_dac_model.got.delete();
      repeat (12) @(posedge ref_clk);
      #1;
      rst_b = 1;
      in_valid = 1;
      for (k = 0; k < N + 8; k++) begin
        in_sol = k % 16 == 0;
        in_sof = k == 0;
        {in_y, in_u, in_v} = {11'(ys[k]), 10'(us[k]), 10'(vs[k])};
        for (w = 0; w < 100; w++) begin
          if (in_ready === 1'b1) break;
          @(posedge ref_clk);
          #1;
        end
        if (w == 100) begin
          n_errors++;
          summarize();
        end
        @(posedge ref_clk);
        #1;
      end
      in_valid = 0;
      `CHK("hpos", 10'h008, cur_hpos)
      `CHK("vpos", 10'h006, cur_vpos)
      for (w = 0; w < 3000 && u_vopp_dac_model.got.size() < N; w++) @(posedge ref_clk);
      if (w == 3000) begin
        n_errors++;
        summarize();
      end
      for (k = 0; k < N; k++) begin
        e = expect_at(k);
        g = u_vopp_dac_model.got[k];
        if (k >= $signed(luma_delay)) `CHK("luma", e[29:20], g[29:20])
        `CHK("chroma", e[19:0], g[19:0])
      end
      $display("test %0d done", t);
    end
    summarize();
  end
endmodule
`default_nettype wire
